// file: hdl/rcad_pkg.sv
// shared constants and types of the 8-bit core datapath
// assumes one 20 MHz clock; every user names items as rcad_pkg::name
package rcad_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int PHASE_COUNT = INSTR_CYCLE_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int WORD_W = 14;
  localparam int PC_W = 13;
  localparam int PM_DEPTH = 2048;
  localparam int RAM_DEPTH = 128;
  localparam int STACK_DEPTH = 8;
  localparam logic [PC_W-1:0] PM_MASK_512 = 13'h01ff;
  localparam logic [PC_W-1:0] PM_MASK_1K = 13'h03ff;
  localparam logic [PC_W-1:0] PM_MASK_2K = 13'h07ff;
  localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;

  // ****************************************************************
  // register port map
  // ****************************************************************
  localparam logic [11:0] OFS_PROG_TOP = 12'h7ff;
  localparam logic [11:0] OFS_CTRL = 12'h800;
  localparam logic [11:0] OFS_ACCUM = 12'h801;
  localparam logic [11:0] OFS_FLAGS = 12'h802;
  localparam logic [11:0] OFS_PC = 12'h803;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SIZE_LSB = 1;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [1:0] SIZE_512 = 2'h0;
  localparam logic [1:0] SIZE_1K = 2'h1;

  // ****************************************************************
  // data memory map and flag layout
  // ****************************************************************
  localparam logic [6:0] FA_INDIRECT = 7'h00;
  localparam logic [6:0] FA_PCL = 7'h02;
  localparam logic [6:0] FA_FLAGS = 7'h03;
  localparam logic [6:0] FA_FSR = 7'h04;
  localparam logic [6:0] FA_PCLATH = 7'h0a;
  localparam int FLAG_MSB_OVF = 0;
  localparam int FLAG_NIB_OVF = 1;
  localparam int FLAG_NULL = 2;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC,
    ALU_DEC, ALU_RR, ALU_RL, ALU_SWAP, ALU_CLR, ALU_BCLR, ALU_BSET
  } rcad_alu_op_t;

  typedef enum logic {
    ST_HALT, ST_RUN
  } rcad_state_t;

endpackage : rcad_pkg

// file: hdl/rcad_phase.sv
// four-phase instruction cycle generator
// assumes the core clock is the device clock; phases are one-cycle enables
`timescale 1ns/1ps
module rcad_phase (
  input wire logic clk,
  input wire logic reset_n,
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  always_comb begin
    if (cnt_reg == 2'(rcad_pkg::PHASE_COUNT - 1)) begin
      cnt_next = 2'h0;
    end else begin
      cnt_next = cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign phase_one = (cnt_reg == 2'h0);
  assign phase_two = (cnt_reg == 2'h1);
  assign phase_three = (cnt_reg == 2'h2);
  assign phase_four = (cnt_reg == 2'h3);

endmodule : rcad_phase

// file: hdl/rcad_alu.sv
// 8-bit two's-complement arithmetic and logic unit
// assumes the caller decides which flags an operation may change
`timescale 1ns/1ps
module rcad_alu (
  input wire rcad_pkg::rcad_alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  input wire logic [2:0] bit_sel,
  output logic [7:0] res,
  output logic carry_out,
  output logic nibble_out,
  output logic zero_out
);

  logic [8:0] sum9;
  logic [4:0] nib5;

  always_comb begin
    sum9 = 9'h000;
    nib5 = 5'h00;
    res = b;
    carry_out = carry_in;
    nibble_out = 1'b0;
    case (op)
      rcad_pkg::ALU_ADD: begin
        sum9 = {1'b0, a} + {1'b0, b};
        nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        res = sum9[7:0];
        carry_out = sum9[8];
        nibble_out = nib5[4];
      end
      rcad_pkg::ALU_SUB: begin
        // b minus a as b + ~a + 1: carries out mean no borrow
        sum9 = {1'b0, b} + {1'b0, ~a} + 9'h001;
        nib5 = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        res = sum9[7:0];
        carry_out = sum9[8];
        nibble_out = nib5[4];
      end
      rcad_pkg::ALU_AND: res = a & b;
      rcad_pkg::ALU_IOR: res = a | b;
      rcad_pkg::ALU_XOR: res = a ^ b;
      rcad_pkg::ALU_COM: res = ~b;
      rcad_pkg::ALU_INC: res = b + 8'h01;
      rcad_pkg::ALU_DEC: res = b - 8'h01;
      rcad_pkg::ALU_RR: begin
        res = {carry_in, b[7:1]};
        carry_out = b[0];
      end
      rcad_pkg::ALU_RL: begin
        res = {b[6:0], carry_in};
        carry_out = b[7];
      end
      rcad_pkg::ALU_SWAP: res = {b[3:0], b[7:4]};
      rcad_pkg::ALU_CLR: res = 8'h00;
      rcad_pkg::ALU_BCLR: res = b & ~(8'h01 << bit_sel);
      rcad_pkg::ALU_BSET: res = b | (8'h01 << bit_sel);
      default: res = b;
    endcase
    zero_out = (res == 8'h00);
  end

endmodule : rcad_alu

// file: hdl/rcad_core.sv
// 8-bit core datapath: program store, two-stage pipeline, decode, data memory
// assumes a synchronous host port; software loads program words then sets run
`timescale 1ns/1ps
module rcad_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  output logic cycle_clk_out
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [rcad_pkg::WORD_W-1:0] prog_mem [rcad_pkg::PM_DEPTH];
  logic [7:0] ram_mem [rcad_pkg::RAM_DEPTH];
  logic [rcad_pkg::PC_W-1:0] stack_mem [rcad_pkg::STACK_DEPTH];

  rcad_pkg::rcad_state_t state_reg, state_next;
  logic [rcad_pkg::PC_W-1:0] pc_reg, pc_next;
  logic [rcad_pkg::WORD_W-1:0] instr_reg, instr_next;
  logic [7:0] accum_reg, accum_next;
  logic [2:0] alu_flags_reg, alu_flags_next;
  logic [7:0] fsr_reg, fsr_next;
  logic [4:0] pclath_reg, pclath_next;
  logic [2:0] sp_reg, sp_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [15:0] rdata_reg, rdata_next;
  logic cyc_reg, cyc_next;

  logic phase_three, phase_four;
  logic [rcad_pkg::WORD_W-1:0] fetch_word;
  logic [rcad_pkg::PC_W-1:0] pc_mask, pc_inc;
  logic [6:0] fa;
  logic [7:0] file_rd;
  rcad_pkg::rcad_alu_op_t alu_op;
  logic [7:0] alu_b, alu_res;
  logic alu_c, alu_dc, alu_z;
  logic wr_res, dest_file, upd_c, upd_dc, upd_z, flush, skip, push, pop;
  logic [rcad_pkg::PC_W-1:0] target;
  logic ram_we;
  logic [6:0] ram_wa;
  logic [7:0] ram_wd;
  logic pm_we;

  rcad_phase u_phase (
    .clk(clk),
    .reset_n(reset_n),
    .phase_one(),
    .phase_two(),
    .phase_three(phase_three),
    .phase_four(phase_four)
  );

  rcad_alu u_alu (
    .op(alu_op),
    .a(accum_reg),
    .b(alu_b),
    .carry_in(alu_flags_reg[rcad_pkg::FLAG_MSB_OVF]),
    .bit_sel(instr_reg[9:7]),
    .res(alu_res),
    .carry_out(alu_c),
    .nibble_out(alu_dc),
    .zero_out(alu_z)
  );

  // ****************************************************************
  // fetch path and operand selection
  // ****************************************************************
  always_comb begin
    if (ctrl_reg[rcad_pkg::CTRL_SIZE_LSB +: 2] == rcad_pkg::SIZE_512) begin
      pc_mask = rcad_pkg::PM_MASK_512;
    end else if (ctrl_reg[rcad_pkg::CTRL_SIZE_LSB +: 2] == rcad_pkg::SIZE_1K) begin
      pc_mask = rcad_pkg::PM_MASK_1K;
    end else begin
      pc_mask = rcad_pkg::PM_MASK_2K;
    end
  end

  // addresses past the fitted size wrap, nothing outside is ever reached
  assign fetch_word = prog_mem[pc_reg[10:0]];
  assign pc_inc = (pc_reg + 13'h0001) & pc_mask;
  // the null file address selects the pointer register instead
  assign fa = (instr_reg[6:0] == rcad_pkg::FA_INDIRECT) ? fsr_reg[6:0] : instr_reg[6:0];

  always_comb begin
    if (fa == rcad_pkg::FA_INDIRECT) begin
      file_rd = 8'h00;
    end else if (fa == rcad_pkg::FA_PCL) begin
      file_rd = pc_reg[7:0];
    end else if (fa == rcad_pkg::FA_FLAGS) begin
      file_rd = {5'h00, alu_flags_reg};
    end else if (fa == rcad_pkg::FA_FSR) begin
      file_rd = fsr_reg;
    end else if (fa == rcad_pkg::FA_PCLATH) begin
      file_rd = {3'h0, pclath_reg};
    end else begin
      file_rd = ram_mem[fa];
    end
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  always_comb begin
    alu_op = rcad_pkg::ALU_PASS;
    alu_b = file_rd;
    wr_res = 1'b0;
    dest_file = instr_reg[7];
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    flush = 1'b0;
    skip = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    target = pc_inc;
    casez (instr_reg)
      14'b00_0000_1???????: begin
        alu_b = accum_reg;
        wr_res = 1'b1;
      end
      14'b00_0000_0000100?: begin
        pop = 1'b1;
        flush = 1'b1;
        target = stack_mem[sp_reg - 3'h1];
      end
      14'b00_0001_????????: begin
        alu_op = rcad_pkg::ALU_CLR;
        wr_res = 1'b1;
        upd_z = 1'b1;
      end
      14'b00_0010_????????: begin
        alu_op = rcad_pkg::ALU_SUB;
        {wr_res, upd_c, upd_dc, upd_z} = 4'hf;
      end
      14'b00_0011_????????: begin
        alu_op = rcad_pkg::ALU_DEC;
        {wr_res, upd_z} = 2'h3;
      end
      14'b00_0100_????????: begin
        alu_op = rcad_pkg::ALU_IOR;
        {wr_res, upd_z} = 2'h3;
      end
      14'b00_0101_????????: begin
        alu_op = rcad_pkg::ALU_AND;
        {wr_res, upd_z} = 2'h3;
      end
      14'b00_0110_????????: begin
        alu_op = rcad_pkg::ALU_XOR;
        {wr_res, upd_z} = 2'h3;
      end
      14'b00_0111_????????: begin
        alu_op = rcad_pkg::ALU_ADD;
        {wr_res, upd_c, upd_dc, upd_z} = 4'hf;
      end
      14'b00_1000_????????: {wr_res, upd_z} = 2'h3;
      14'b00_1001_????????: begin
        alu_op = rcad_pkg::ALU_COM;
        {wr_res, upd_z} = 2'h3;
      end
      14'b00_1010_????????: begin
        alu_op = rcad_pkg::ALU_INC;
        {wr_res, upd_z} = 2'h3;
      end
      14'b00_1011_????????: begin
        alu_op = rcad_pkg::ALU_DEC;
        wr_res = 1'b1;
        skip = (alu_res == 8'h00);
      end
      14'b00_1100_????????: begin
        alu_op = rcad_pkg::ALU_RR;
        {wr_res, upd_c} = 2'h3;
      end
      14'b00_1101_????????: begin
        alu_op = rcad_pkg::ALU_RL;
        {wr_res, upd_c} = 2'h3;
      end
      14'b00_1110_????????: begin
        alu_op = rcad_pkg::ALU_SWAP;
        wr_res = 1'b1;
      end
      14'b00_1111_????????: begin
        alu_op = rcad_pkg::ALU_INC;
        wr_res = 1'b1;
        skip = (alu_res == 8'h00);
      end
      14'b01_00??_????????: begin
        alu_op = rcad_pkg::ALU_BCLR;
        {wr_res, dest_file} = 2'h3;
      end
      14'b01_01??_????????: begin
        alu_op = rcad_pkg::ALU_BSET;
        {wr_res, dest_file} = 2'h3;
      end
      14'b01_10??_????????: skip = ~file_rd[instr_reg[9:7]];
      14'b01_11??_????????: skip = file_rd[instr_reg[9:7]];
      14'b10_0???_????????: begin
        push = 1'b1;
        flush = 1'b1;
        target = {pclath_reg[4:3], instr_reg[10:0]} & pc_mask;
      end
      14'b10_1???_????????: begin
        flush = 1'b1;
        target = {pclath_reg[4:3], instr_reg[10:0]} & pc_mask;
      end
      14'b11_00??_????????: begin
        alu_b = instr_reg[7:0];
        {wr_res, dest_file} = 2'h2;
      end
      14'b11_01??_????????: begin
        alu_b = instr_reg[7:0];
        {wr_res, dest_file, pop, flush} = 4'hb;
        target = stack_mem[sp_reg - 3'h1];
      end
      14'b11_1000_????????: begin
        alu_op = rcad_pkg::ALU_IOR;
        alu_b = instr_reg[7:0];
        {wr_res, dest_file, upd_z} = 3'h5;
      end
      14'b11_1001_????????: begin
        alu_op = rcad_pkg::ALU_AND;
        alu_b = instr_reg[7:0];
        {wr_res, dest_file, upd_z} = 3'h5;
      end
      14'b11_1010_????????: begin
        alu_op = rcad_pkg::ALU_XOR;
        alu_b = instr_reg[7:0];
        {wr_res, dest_file, upd_z} = 3'h5;
      end
      14'b11_110?_????????: begin
        alu_op = rcad_pkg::ALU_SUB;
        alu_b = instr_reg[7:0];
        {wr_res, dest_file, upd_c, upd_dc, upd_z} = 5'h17;
      end
      14'b11_111?_????????: begin
        alu_op = rcad_pkg::ALU_ADD;
        alu_b = instr_reg[7:0];
        {wr_res, dest_file, upd_c, upd_dc, upd_z} = 5'h17;
      end
      // remaining words (idle, sleep, watchdog clear) act as no operation
      default: wr_res = 1'b0;
    endcase
    if (wr_res && dest_file && fa == rcad_pkg::FA_PCL) begin
      flush = 1'b1;
      target = {pclath_reg, alu_res} & pc_mask;
    end
  end

  // ****************************************************************
  // execute, pipeline and register port
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    instr_next = instr_reg;
    accum_next = accum_reg;
    alu_flags_next = alu_flags_reg;
    fsr_next = fsr_reg;
    pclath_next = pclath_reg;
    sp_next = sp_reg;
    ctrl_next = ctrl_reg;
    ram_we = 1'b0;
    ram_wa = fa;
    ram_wd = alu_res;
    pm_we = bus_wr && (bus_addr <= rcad_pkg::OFS_PROG_TOP);
    rdata_next = 16'h0000;
    cyc_next = phase_three | phase_four;
    if (bus_wr && bus_addr == rcad_pkg::OFS_CTRL) begin
      ctrl_next = bus_wdata[2:0];
    end
    case (state_reg)
      rcad_pkg::ST_HALT: begin
        if (ctrl_reg[rcad_pkg::CTRL_RUN_BIT] && phase_four) begin
          state_next = rcad_pkg::ST_RUN;
          instr_next = rcad_pkg::NOP_WORD;
        end
      end
      rcad_pkg::ST_RUN: begin
        if (!ctrl_reg[rcad_pkg::CTRL_RUN_BIT]) begin
          state_next = rcad_pkg::ST_HALT;
        end else if (phase_four) begin
          instr_next = fetch_word;
          pc_next = pc_inc;
          if (wr_res && !dest_file) begin
            accum_next = alu_res;
          end else if (wr_res) begin
            if (fa == rcad_pkg::FA_FLAGS) begin
              alu_flags_next = alu_res[2:0];
            end else if (fa == rcad_pkg::FA_FSR) begin
              fsr_next = alu_res;
            end else if (fa == rcad_pkg::FA_PCLATH) begin
              pclath_next = alu_res[4:0];
            end else if (fa != rcad_pkg::FA_PCL && fa != rcad_pkg::FA_INDIRECT) begin
              ram_we = 1'b1;
            end
          end
          // flag updates win over a direct write to the flag register
          if (upd_c) alu_flags_next[rcad_pkg::FLAG_MSB_OVF] = alu_c;
          if (upd_dc) alu_flags_next[rcad_pkg::FLAG_NIB_OVF] = alu_dc;
          if (upd_z) alu_flags_next[rcad_pkg::FLAG_NULL] = alu_z;
          if (push) sp_next = sp_reg + 3'h1;
          if (pop) sp_next = sp_reg - 3'h1;
          if (flush) begin
            instr_next = rcad_pkg::NOP_WORD;
            pc_next = target;
          end else if (skip) begin
            instr_next = rcad_pkg::NOP_WORD;
          end
        end
      end
      default: state_next = rcad_pkg::ST_HALT;
    endcase
    if (bus_rd) begin
      if (bus_addr <= rcad_pkg::OFS_PROG_TOP) begin
        rdata_next = {2'h0, prog_mem[bus_addr[10:0]]};
      end else if (bus_addr == rcad_pkg::OFS_CTRL) begin
        rdata_next = {13'h0000, ctrl_reg};
      end else if (bus_addr == rcad_pkg::OFS_ACCUM) begin
        rdata_next = {8'h00, accum_reg};
      end else if (bus_addr == rcad_pkg::OFS_FLAGS) begin
        rdata_next = {13'h0000, alu_flags_reg};
      end else if (bus_addr == rcad_pkg::OFS_PC) begin
        rdata_next = {3'h0, pc_reg};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= rcad_pkg::ST_HALT;
      pc_reg <= '0;
      instr_reg <= rcad_pkg::NOP_WORD;
      accum_reg <= 8'h00;
      alu_flags_reg <= rcad_pkg::FLAGS_RESET;
      fsr_reg <= 8'h00;
      pclath_reg <= 5'h00;
      sp_reg <= 3'h0;
      ctrl_reg <= rcad_pkg::CTRL_RESET;
      rdata_reg <= 16'h0000;
      cyc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      instr_reg <= instr_next;
      accum_reg <= accum_next;
      alu_flags_reg <= alu_flags_next;
      fsr_reg <= fsr_next;
      pclath_reg <= pclath_next;
      sp_reg <= sp_next;
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      cyc_reg <= cyc_next;
    end
  end

  // memories hold no reset; program and data write enables are computed above, the stack's here
  always_ff @(posedge clk) begin
    if (pm_we) begin
      prog_mem[bus_addr[10:0]] <= bus_wdata[13:0];
    end
    if (ram_we) begin
      ram_mem[ram_wa] <= ram_wd;
    end
    if (state_reg == rcad_pkg::ST_RUN && phase_four && push) begin
      stack_mem[sp_reg] <= pc_reg;
    end
  end

  assign bus_rdata = rdata_reg;
  assign cycle_clk_out = cyc_reg;

endmodule : rcad_core

// file: tb/rcad_core_asserts.sv
// checker for the core register port and the instruction-cycle clock
// assumes it is bound to rcad_core and sees only that module's ports
`timescale 1ns/1ps
module rcad_core_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic cycle_clk_out
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // write data two edges back, so a write followed by a read can be judged
  logic [15:0] wd1_reg;
  logic [15:0] wd2_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd1_reg <= 16'h0000;
      wd2_reg <= 16'h0000;
    end else begin
      wd1_reg <= bus_wdata;
      wd2_reg <= wd1_reg;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // properties
  // ****************************************************************
  rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_zero_a: assert property (bus_rd && bus_addr >= 12'h804 |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  prog_width_a: assert property (bus_rd && bus_addr <= 12'h7ff |=> bus_rdata[15:14] == 2'h0)
    else $error("program word wider than 14 bits");
  prog_readback_a: assert property (bus_wr && bus_addr <= 12'h7ff ##1
    bus_rd && bus_addr == $past(bus_addr) |=> bus_rdata == {2'h0, wd2_reg[13:0]})
    else $error("program word read back wrong");
  ctrl_readback_a: assert property (bus_wr && bus_addr == 12'h800 ##1
    bus_rd && bus_addr == 12'h800 |=> bus_rdata[2:0] == wd2_reg[2:0])
    else $error("control read back wrong");
  accum_width_a: assert property (bus_rd && bus_addr == 12'h801 |=> bus_rdata[15:8] == 8'h00)
    else $error("accumulator wider than 8 bits");
  flags_width_a: assert property (bus_rd && bus_addr == 12'h802 |=> bus_rdata[15:3] == 13'h0)
    else $error("flags wider than 3 bits");
  pc_range_a: assert property (bus_rd && bus_addr == 12'h803 |=> bus_rdata[15:11] == 5'h00)
    else $error("program counter beyond 2K words");
  cycle_shape_a: assert property ($rose(cycle_clk_out) |=>
    cycle_clk_out ##1 !cycle_clk_out[*2] ##1 cycle_clk_out)
    else $error("cycle clock not two high two low");
  cycle_gap_a: assert property ($fell(cycle_clk_out) |-> ##2 $rose(cycle_clk_out))
    else $error("cycle clock period not four clocks");
endmodule : rcad_core_asserts

bind rcad_core rcad_core_asserts u_asserts (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .cycle_clk_out(cycle_clk_out));

// file: tb/tb_risc_core_alu_datapath.sv
// self-checking bench for the core: register port, short programs, flags
// assumes rcad_core with the register map of rcad_pkg and a 20 MHz clock
`timescale 1ns/1ps
module tb_risc_core_alu_datapath;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] bus_addr = 12'h000;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic cycle_clk_out;
  logic [15:0] rv;
  int miscompares = 0;
  int n_checks = 0;

  rcad_core dut (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cycle_clk_out(cycle_clk_out));

  initial begin
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask : chk

  // a write leaves its strobe up; the next read or idle lowers it
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bus_rd <= 1'b0;
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 rv = bus_rdata;
    @(posedge clk);
  endtask : rd

  task automatic rchk(input logic [11:0] a, input logic [15:0] exp, input string what);
    rd(a);
    chk(what, rv, exp);
  endtask : rchk

  task automatic idle(input int n);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic reset_dut();
    reset_n <= 1'b0;
    idle(8);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask : reset_dut

  // five words then a jump to self, so results stay put while read
  task automatic run_prog(input logic [15:0] w0, w1, w2, w3, w4);
    reset_dut();
    wr(12'h000, w0);
    wr(12'h001, w1);
    wr(12'h002, w2);
    wr(12'h003, w3);
    wr(12'h004, w4);
    wr(12'h005, 16'h2805);
    wr(12'h800, 16'h0005);
    idle(80);
  endtask : run_prog

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    reset_dut();
    rchk(12'h800, 16'h0004, "ctrl reset");
    rchk(12'h801, 16'h0000, "accum reset");
    rchk(12'h802, 16'h0000, "flags reset");
    rchk(12'h803, 16'h0000, "pc reset");
    wr(12'h801, 16'h00ff);
    rchk(12'h801, 16'h0000, "accum read only");
    wr(12'h804, 16'hffff);
    rchk(12'h804, 16'h0000, "unmapped");
    wr(12'h7ff, 16'hffff);
    rchk(12'h7ff, 16'h3fff, "prog top word");
    wr(12'h800, 16'h0002);
    rchk(12'h800, 16'h0002, "ctrl rw");
  endtask : t_regs

  task automatic t_alu();
    run_prog(16'h3003, 16'h3c05, 16'h0000, 16'h0000, 16'h0000);
    rchk(12'h801, 16'h0002, "sub acc");
    rchk(12'h802, 16'h0003, "sub no borrow");
    run_prog(16'h3005, 16'h3c03, 16'h0000, 16'h0000, 16'h0000);
    rchk(12'h801, 16'h00fe, "sub neg acc");
    rchk(12'h802, 16'h0000, "sub borrow");
    run_prog(16'h3001, 16'h3c10, 16'h0000, 16'h0000, 16'h0000);
    rchk(12'h801, 16'h000f, "sub nibble acc");
    rchk(12'h802, 16'h0001, "nibble borrow");
    run_prog(16'h30f8, 16'h3e08, 16'h0000, 16'h0000, 16'h0000);
    rchk(12'h801, 16'h0000, "add wrap acc");
    rchk(12'h802, 16'h0007, "add all flags");
    run_prog(16'h300f, 16'h3e01, 16'h0000, 16'h0000, 16'h0000);
    rchk(12'h801, 16'h0010, "add nibble acc");
    rchk(12'h802, 16'h0002, "add nibble flag");
    run_prog(16'h30f0, 16'h393c, 16'h0000, 16'h0000, 16'h0000);
    rchk(12'h801, 16'h0030, "and acc");
    run_prog(16'h3055, 16'h3a55, 16'h0000, 16'h0000, 16'h0000);
    rchk(12'h802, 16'h0004, "xor null");
    run_prog(16'h3000, 16'h3800, 16'h3801, 16'h0000, 16'h0000);
    rchk(12'h801, 16'h0001, "ior acc");
    rchk(12'h802, 16'h0000, "null cleared");
    run_prog(16'h3081, 16'h00a0, 16'h0d20, 16'h0000, 16'h0000);
    rchk(12'h801, 16'h0002, "rotate acc");
    rchk(12'h802, 16'h0001, "rotate carry");
    run_prog(16'h3009, 16'h00a0, 16'h3009, 16'h0220, 16'h0000);
    rchk(12'h801, 16'h0000, "file sub acc");
    rchk(12'h802, 16'h0007, "file sub flags");
    run_prog(16'h3020, 16'h0084, 16'h3033, 16'h0080, 16'h0820);
    rchk(12'h801, 16'h0033, "indirect");
    rchk(12'h802, 16'h0000, "move nonzero");
  endtask : t_alu

  // the word after a taken branch, skip or counter write must never reach the accumulator
  task automatic t_flow();
    run_prog(16'h2803, 16'h3077, 16'h0000, 16'h3e01, 16'h0000);
    rchk(12'h801, 16'h0001, "goto flush acc");
    run_prog(16'h2003, 16'h3e01, 16'h2805, 16'h3440, 16'h0000);
    rchk(12'h801, 16'h0041, "call retlw acc");
    run_prog(16'h01a1, 16'h15a1, 16'h1da1, 16'h3077, 16'h0721);
    rchk(12'h801, 16'h0008, "bit skip acc");
    run_prog(16'h3002, 16'h00a2, 16'h0ba2, 16'h2802, 16'h0922);
    rchk(12'h801, 16'h00ff, "count loop acc");
    rchk(12'h802, 16'h0000, "com flags");
    run_prog(16'h3004, 16'h0082, 16'h3077, 16'h0000, 16'h3e01);
    rchk(12'h801, 16'h0005, "pcl write acc");
  endtask : t_flow

  // 512-word size: fetch past the top wraps to zero, so 0x200 never runs
  task automatic t_wrap();
    reset_dut();
    wr(12'h000, 16'h29ff);
    wr(12'h1ff, 16'h3042);
    wr(12'h200, 16'h3099);
    wr(12'h800, 16'h0001);
    idle(120);
    rchk(12'h801, 16'h0042, "wrap acc");
    rd(12'h803);
    chk("wrap pc", rv & 16'hfe00, 16'h0000);
  endtask : t_wrap

  initial begin
    t_regs();
    t_alu();
    t_flow();
    t_wrap();
    summarize();
  end

  // the tests take about 2000 clocks; twenty thousand means a hang
  initial begin
    #1000000;
    miscompares++;
    summarize();
  end
endmodule : tb_risc_core_alu_datapath
